// File: hw/brf_top.sv
// brf_top: banked register file, program counter, current and saved status words
// assumes: execute pipeline issues at most one op of each kind per cycle
`timescale 1ns/1ps
module brf_top #(
   parameter int unsigned DATA_W = 32
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [3:0]        rd_a_spec,
   input  wire logic [3:0]        rd_b_spec,
   output logic      [DATA_W-1:0] rd_a_data,
   output logic      [DATA_W-1:0] rd_b_data,
   input  wire logic              wr_en,
   input  wire logic [3:0]        wr_spec,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              branch_with_link,
   input  wire logic              pc_advance,
   input  wire logic              pc_load,
   input  wire logic [DATA_W-1:0] pc_target,
   input  wire logic              flags_we,
   input  wire logic [3:0]        cond_flags_in,
   input  wire logic              sat_set,
   input  wire logic              lane_we,
   input  wire logic [3:0]        lane_compare_in,
   input  wire logic              status_wr_cur,
   input  wire logic              status_wr_saved,
   input  wire logic [DATA_W-1:0] status_wr_data,
   input  wire logic              status_rd_saved,
   output logic      [DATA_W-1:0] status_rd_data,
   input  wire logic              exc_req,
   input  wire logic [2:0]        exc_kind,
   input  wire logic [DATA_W-1:0] exc_return_addr,
   output logic      [DATA_W-1:0] fetch_pc,
   output logic      [DATA_W-1:0] current_status_word,
   output logic      [4:0]        mode,
   output logic                   privileged,
   output logic                   big_endian,
   output logic                   irq_masked,
   output logic                   fast_irq_masked,
   output logic                   abort_masked,
   output logic      [1:0]        istate
);
   // ***************************************************************
   // mapping functions
   // ***************************************************************
   // physical layout: 0..14 user/system, 15..19 fast 8-12, 20..21 fast 13-14,
   // 22..23 irq, 24..25 trap, 26..27 abort, 28..29 undef; counter is separate
   function automatic logic [4:0] map_phys(input logic [3:0] spec, input logic [4:0] md);
      logic [4:0] base;
      base = 5'h00;
      case (md)
         brf_pkg::MODE_FAST:  base = 5'h14;
         brf_pkg::MODE_IRQ:   base = 5'h16;
         brf_pkg::MODE_TRAP:  base = 5'h18;
         brf_pkg::MODE_ABORT: base = 5'h1A;
         brf_pkg::MODE_UNDEF: base = 5'h1C;
         default:             base = 5'h00;
      endcase
      if ((md == brf_pkg::MODE_FAST) && (spec >= brf_pkg::FAST_BANK_LO) && (spec <= brf_pkg::FAST_BANK_HI)) begin
         map_phys = 5'(spec) + 5'h07;
      end else if ((base != 5'h00) && (spec >= brf_pkg::STACK_REG_IDX)) begin
         map_phys = base + 5'(spec - brf_pkg::STACK_REG_IDX);
      end else begin
         map_phys = 5'(spec);
      end
   endfunction : map_phys

   function automatic logic [2:0] saved_slot(input logic [4:0] md);
      case (md)
         brf_pkg::MODE_FAST:  saved_slot = 3'h0;
         brf_pkg::MODE_IRQ:   saved_slot = 3'h1;
         brf_pkg::MODE_TRAP:  saved_slot = 3'h2;
         brf_pkg::MODE_ABORT: saved_slot = 3'h3;
         brf_pkg::MODE_UNDEF: saved_slot = 3'h4;
         default:             saved_slot = 3'h7;
      endcase
   endfunction : saved_slot

   function automatic logic [31:0] align_pc(input logic [31:0] a, input logic [1:0] st);
      case (st)
         brf_pkg::ISTATE_HALF: align_pc = {a[31:1], 1'b0};
         brf_pkg::ISTATE_BYTE: align_pc = a;
         default:              align_pc = {a[31:2], 2'b00};
      endcase
   endfunction : align_pc

   function automatic logic [1:0] state_of(input logic [31:0] w);
      state_of = {w[brf_pkg::BYTECODE_POS], w[brf_pkg::HALF_POS]};
   endfunction : state_of

   // ***************************************************************
   // state
   // ***************************************************************
   logic [31:0] status_q;
   logic [31:0] status_d;
   logic [31:0] saved_q [brf_pkg::NUM_SAVED];
   logic [31:0] pc_q;
   logic [31:0] pc_d;
   logic [3:0]  rd_a_spec_q;
   logic [3:0]  rd_b_spec_q;
   logic [31:0] pc_at_read_q;
   logic [31:0] mem_a;
   logic [31:0] mem_b;

   // ***************************************************************
   // decode
   // ***************************************************************
   wire logic [4:0]  cur_mode     = status_q[4:0];
   wire logic        cur_priv     = (cur_mode != brf_pkg::MODE_USER);
   wire logic [2:0]  cur_slot     = saved_slot(cur_mode);
   wire logic        has_saved    = (cur_slot != 3'h7);
   wire logic [4:0]  rd_a_phys    = map_phys(rd_a_spec, cur_mode);
   wire logic [4:0]  rd_b_phys    = map_phys(rd_b_spec, cur_mode);
   wire logic [31:0] pc_operand   = pc_q + brf_pkg::PC_AHEAD_BYTES;

   // exception target mode and vector
   logic [4:0]  exc_mode;
   logic [31:0] exc_vec;
   logic        exc_mask_fast;
   always_comb begin
      exc_mask_fast = 1'b0;
      case (exc_kind)
         brf_pkg::EXC_RESET:  begin exc_mode = brf_pkg::MODE_TRAP;  exc_vec = brf_pkg::VEC_RESET; exc_mask_fast = 1'b1; end
         brf_pkg::EXC_UNDEF:  begin exc_mode = brf_pkg::MODE_UNDEF; exc_vec = brf_pkg::VEC_UNDEF;  end
         brf_pkg::EXC_TRAP:   begin exc_mode = brf_pkg::MODE_TRAP;  exc_vec = brf_pkg::VEC_TRAP;   end
         brf_pkg::EXC_PABORT: begin exc_mode = brf_pkg::MODE_ABORT; exc_vec = brf_pkg::VEC_PABORT; end
         brf_pkg::EXC_DABORT: begin exc_mode = brf_pkg::MODE_ABORT; exc_vec = brf_pkg::VEC_DABORT; end
         brf_pkg::EXC_IRQ:    begin exc_mode = brf_pkg::MODE_IRQ;   exc_vec = brf_pkg::VEC_IRQ;    end
         brf_pkg::EXC_FAST:   begin exc_mode = brf_pkg::MODE_FAST;  exc_vec = brf_pkg::VEC_FAST; exc_mask_fast = 1'b1; end
         default:             begin exc_mode = brf_pkg::MODE_UNDEF; exc_vec = brf_pkg::VEC_UNDEF;  end
      endcase
   end

   // general register write: exception link beats branch link beats normal write
   logic        gw_en;
   logic [4:0]  gw_idx;
   logic [31:0] gw_data;
   always_comb begin
      gw_en   = 1'b0;
      gw_idx  = 5'h00;
      gw_data = 32'h00000000;
      if (exc_req && (exc_kind != brf_pkg::EXC_RESET)) begin
         gw_en   = 1'b1;
         gw_idx  = map_phys(brf_pkg::RETURN_LINK_INDEX, exc_mode);
         gw_data = exc_return_addr;
      end else if (branch_with_link) begin
         gw_en   = 1'b1;
         gw_idx  = map_phys(brf_pkg::RETURN_LINK_INDEX, cur_mode);
         gw_data = pc_q + 32'h00000004;
      end else if (wr_en && (wr_spec != brf_pkg::PROGRAM_COUNTER_INDEX)) begin
         gw_en   = 1'b1;
         gw_idx  = map_phys(wr_spec, cur_mode);
         gw_data = wr_data;
      end
   end

   // current status word next value
   logic [31:0] cur_wr_val;
   always_comb begin
      cur_wr_val = status_wr_data & brf_pkg::STATUS_IMPL_MASK;
      if (!cur_priv) begin
         // user code may touch flags, sat and lane bits only; control half stays put
         cur_wr_val[15:0] = status_q[15:0];
         cur_wr_val[brf_pkg::BYTECODE_POS] = status_q[brf_pkg::BYTECODE_POS];
      end
      status_d = status_q;
      if (exc_req) begin
         status_d[4:0] = exc_mode;
         status_d[brf_pkg::HALF_POS]     = 1'b0;
         status_d[brf_pkg::BYTECODE_POS] = 1'b0;
         status_d[brf_pkg::IRQ_M_POS]    = 1'b1;
         status_d[brf_pkg::FAST_M_POS]   = status_q[brf_pkg::FAST_M_POS] | exc_mask_fast;
         // a saturation in the entry cycle must not be lost
         status_d[brf_pkg::SAT_POS]      = status_q[brf_pkg::SAT_POS] | sat_set;
      end else if (status_wr_cur) begin
         status_d = cur_wr_val;
         status_d[brf_pkg::SAT_POS] = cur_wr_val[brf_pkg::SAT_POS] | sat_set;
      end else begin
         if (flags_we) begin
            status_d[brf_pkg::FLAG_N_POS:brf_pkg::FLAG_V_POS] = cond_flags_in;
         end
         if (lane_we) begin
            status_d[brf_pkg::LANE_LO_POS+3:brf_pkg::LANE_LO_POS] = lane_compare_in;
         end
         status_d[brf_pkg::SAT_POS] = status_q[brf_pkg::SAT_POS] | sat_set;
      end
   end

   always_comb begin
      pc_d = pc_q;
      if (exc_req) begin
         pc_d = exc_vec;
      end else if (pc_load || (wr_en && (wr_spec == brf_pkg::PROGRAM_COUNTER_INDEX))) begin
         pc_d = align_pc(pc_load ? pc_target : wr_data, state_of(status_q));
      end else if (pc_advance) begin
         pc_d = align_pc(pc_q + ((state_of(status_q) == brf_pkg::ISTATE_WORD) ? 32'h00000004 :
                ((state_of(status_q) == brf_pkg::ISTATE_HALF) ? 32'h00000002 : 32'h00000001)), state_of(status_q));
      end
   end

   // ***************************************************************
   // storage
   // ***************************************************************
   brf_mem #(
      .DEPTH (brf_pkg::NUM_PHYS),
      .WIDTH (32),
      .IDX_W (brf_pkg::PHYS_IDX_W)
   ) u_mem (
      .core_clk  (core_clk),
      .rst       (rst),
      .rd_a_idx  (rd_a_phys),
      .rd_b_idx  (rd_b_phys),
      .rd_a_data (mem_a),
      .rd_b_data (mem_b),
      .wr_en     (gw_en),
      .wr_idx    (gw_idx),
      .wr_data   (gw_data)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_q <= brf_pkg::STATUS_RESET;
         pc_q     <= brf_pkg::VEC_RESET;
      end else begin
         status_q <= status_d;
         pc_q     <= pc_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < brf_pkg::NUM_SAVED; i++) begin
            saved_q[i] <= 32'h00000000;
         end
      end else if (exc_req && (exc_kind != brf_pkg::EXC_RESET)) begin
         saved_q[saved_slot(exc_mode)] <= status_q;
      end else if (status_wr_saved && has_saved) begin
         saved_q[cur_slot] <= status_wr_data & brf_pkg::STATUS_IMPL_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_a_spec_q  <= 4'h0;
         rd_b_spec_q  <= 4'h0;
         pc_at_read_q <= 32'h00000000;
      end else begin
         rd_a_spec_q  <= rd_a_spec;
         rd_b_spec_q  <= rd_b_spec;
         pc_at_read_q <= pc_operand;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   // operand ports are the memory's own read registers, muxed with a registered pc
   // copy; the mux select is itself registered so the path stays flop to port
   assign rd_a_data = (rd_a_spec_q == brf_pkg::PROGRAM_COUNTER_INDEX) ? pc_at_read_q : mem_a;
   assign rd_b_data = (rd_b_spec_q == brf_pkg::PROGRAM_COUNTER_INDEX) ? pc_at_read_q : mem_b;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_rd_data <= 32'h00000000;
      end else if (status_rd_saved) begin
         status_rd_data <= has_saved ? saved_q[cur_slot] : status_q;
      end else begin
         status_rd_data <= status_q;
      end
   end

   assign fetch_pc            = pc_q;
   assign current_status_word = status_q;
   assign mode                = status_q[4:0];
   assign privileged          = cur_priv;
   assign big_endian          = status_q[brf_pkg::ENDIAN_POS];
   assign irq_masked          = status_q[brf_pkg::IRQ_M_POS];
   assign fast_irq_masked     = status_q[brf_pkg::FAST_M_POS];
   assign abort_masked        = status_q[brf_pkg::ABORT_M_POS];
   assign istate              = state_of(status_q);
endmodule : brf_top

// File: hw/brf_pkg.sv
// brf_pkg: constants for the banked register file with mode and status words
// assumes: single core clock domain, driven by the execute pipeline
package brf_pkg;
   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int unsigned NUM_PHYS      = 31;
   localparam int unsigned NUM_VISIBLE   = 16;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned PHYS_IDX_W    = 5;
   localparam int unsigned MODE_W        = 5;
   localparam int unsigned NUM_SAVED     = 5;
   localparam int unsigned SAVED_IDX_W   = 3;
   // ***************************************************************
   // visible register roles
   // ***************************************************************
   localparam logic [3:0] STACK_REG_IDX         = 4'hD;
   localparam logic [3:0] RETURN_LINK_INDEX     = 4'hE;
   localparam logic [3:0] PROGRAM_COUNTER_INDEX = 4'hF;
   localparam logic [3:0] FAST_BANK_LO          = 4'h8;
   localparam logic [3:0] FAST_BANK_HI          = 4'hC;
   localparam logic [31:0] PC_AHEAD_BYTES       = 32'h00000008;
   // ***************************************************************
   // status word field positions
   // ***************************************************************
   localparam int unsigned FLAG_N_POS   = 31;
   localparam int unsigned FLAG_Z_POS   = 30;
   localparam int unsigned FLAG_C_POS   = 29;
   localparam int unsigned FLAG_V_POS   = 28;
   localparam int unsigned SAT_POS      = 27;
   localparam int unsigned BYTECODE_POS = 24;
   localparam int unsigned LANE_LO_POS  = 16;
   localparam int unsigned ENDIAN_POS   = 9;
   localparam int unsigned ABORT_M_POS  = 8;
   localparam int unsigned IRQ_M_POS    = 7;
   localparam int unsigned FAST_M_POS   = 6;
   localparam int unsigned HALF_POS     = 5;
   localparam logic [31:0] STATUS_IMPL_MASK = 32'hF90F03FF;
   // ***************************************************************
   // mode encodings
   // ***************************************************************
   localparam logic [4:0] MODE_USER   = 5'h10;
   localparam logic [4:0] MODE_FAST   = 5'h11;
   localparam logic [4:0] MODE_IRQ    = 5'h12;
   localparam logic [4:0] MODE_TRAP   = 5'h13;
   localparam logic [4:0] MODE_ABORT  = 5'h17;
   localparam logic [4:0] MODE_UNDEF  = 5'h1B;
   localparam logic [4:0] MODE_SYSTEM = 5'h1F;
   // reset: trap mode, both interrupts masked, abort masked, 32-bit state
   localparam logic [31:0] STATUS_RESET = 32'h000001D3;
   // ***************************************************************
   // exception kinds and vectors
   // ***************************************************************
   typedef enum logic [2:0] {
      EXC_RESET   = 3'h0,
      EXC_UNDEF   = 3'h1,
      EXC_TRAP    = 3'h2,
      EXC_PABORT  = 3'h3,
      EXC_DABORT  = 3'h4,
      EXC_IRQ     = 3'h6,
      EXC_FAST    = 3'h7
   } brf_exc_type;
   localparam logic [31:0] VEC_RESET  = 32'h00000000;
   localparam logic [31:0] VEC_UNDEF  = 32'h00000004;
   localparam logic [31:0] VEC_TRAP   = 32'h00000008;
   localparam logic [31:0] VEC_PABORT = 32'h0000000C;
   localparam logic [31:0] VEC_DABORT = 32'h00000010;
   localparam logic [31:0] VEC_IRQ    = 32'h00000018;
   localparam logic [31:0] VEC_FAST   = 32'h0000001C;
   // execution state select
   localparam logic [1:0] ISTATE_WORD = 2'h0;
   localparam logic [1:0] ISTATE_HALF = 2'h1;
   localparam logic [1:0] ISTATE_BYTE = 2'h2;
endpackage : brf_pkg

// File: hw/brf_mem.sv
// brf_mem: physical storage for the banked general registers
// assumes: two registered read ports, one write port, same clock
`timescale 1ns/1ps
module brf_mem #(
   parameter int unsigned DEPTH  = 31,
   parameter int unsigned WIDTH  = 32,
   parameter int unsigned IDX_W  = 5
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [IDX_W-1:0] rd_a_idx,
   input  wire logic [IDX_W-1:0] rd_b_idx,
   output logic      [WIDTH-1:0] rd_a_data,
   output logic      [WIDTH-1:0] rd_b_data,
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [WIDTH-1:0] wr_data
);
   logic [WIDTH-1:0] cells_q [DEPTH];
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            cells_q[i] <= '0;
         end
      end else if (wr_en && (wr_idx < IDX_W'(DEPTH))) begin
         cells_q[wr_idx] <= wr_data;
      end
   end
   // out-of-range index reads zero rather than x
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_a_data <= '0;
         rd_b_data <= '0;
      end else begin
         rd_a_data <= (rd_a_idx < IDX_W'(DEPTH)) ? cells_q[rd_a_idx] : '0;
         rd_b_data <= (rd_b_idx < IDX_W'(DEPTH)) ? cells_q[rd_b_idx] : '0;
      end
   end
endmodule : brf_mem

// File: dv/brf_properties.sv
// brf_properties: port-level timing checks for the banked register file
// assumes: one core clock, synchronous active-high reset, bound into brf_top
`timescale 1ns/1ps
module brf_checker (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [3:0]  rd_a_spec,
   input wire logic [31:0] rd_a_data,
   input wire logic        wr_en,
   input wire logic        pc_advance,
   input wire logic        pc_load,
   input wire logic        flags_we,
   input wire logic [3:0]  cond_flags_in,
   input wire logic        sat_set,
   input wire logic        status_wr_cur,
   input wire logic        exc_req,
   input wire logic [2:0]  exc_kind,
   input wire logic [31:0] fetch_pc,
   input wire logic [31:0] current_status_word,
   input wire logic [4:0]  mode,
   input wire logic        privileged,
   input wire logic        irq_masked,
   input wire logic [1:0]  istate
);
   // ************************************************
   // properties
   // ************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   irq_entry_a: assert property (exc_req && exc_kind == 3'h6 |=>
      fetch_pc == 32'h18 && mode == 5'h12 && irq_masked) else $error("irq entry wrong");
   fast_entry_a: assert property (exc_req && exc_kind == 3'h7 |=>
      fetch_pc == 32'h1C && mode == 5'h11) else $error("fast entry wrong");
   reset_entry_a: assert property (exc_req && exc_kind == 3'h0 |=>
      mode == 5'h13 && fetch_pc == 32'h0) else $error("reset entry wrong");
   user_stays_a: assert property (mode == 5'h10 && !exc_req |=> mode == 5'h10)
      else $error("user mode left");
   word_align_a: assert property (istate == 2'h0 |-> fetch_pc[1:0] == 2'h0)
      else $error("pc misaligned");
   pc_step_a: assert property (pc_advance && !pc_load && !wr_en && !exc_req && istate == 2'h0 |=>
      fetch_pc == $past(fetch_pc) + 32'h4) else $error("pc step wrong");
   pc_operand_a: assert property (rd_a_spec == 4'hF |=> rd_a_data == $past(fetch_pc) + 32'h8)
      else $error("pc operand wrong");
   mode_field_a: assert property (current_status_word[4:0] == mode && current_status_word[7] == irq_masked)
      else $error("status fields disagree");
   priv_mode_a: assert property (privileged == (mode != 5'h10))
      else $error("privilege wrong");
   sat_sticky_a: assert property (sat_set || current_status_word[27] && !status_wr_cur |=>
      current_status_word[27]) else $error("sticky bit lost");
   flags_load_a: assert property (flags_we && !status_wr_cur && !exc_req |=>
      current_status_word[31:28] == $past(cond_flags_in)) else $error("flags wrong");
   cover property (exc_req && exc_kind == 3'h7);
   cover property (sat_set ##1 flags_we);
   cover property (rd_a_spec == 4'hF && pc_advance);
endmodule : brf_checker
bind brf_top brf_checker chk (.core_clk(core_clk), .rst(rst), .rd_a_spec(rd_a_spec), .rd_a_data(rd_a_data),
   .wr_en(wr_en), .pc_advance(pc_advance), .pc_load(pc_load), .flags_we(flags_we),
   .cond_flags_in(cond_flags_in), .sat_set(sat_set), .status_wr_cur(status_wr_cur), .exc_req(exc_req),
   .exc_kind(exc_kind), .fetch_pc(fetch_pc), .current_status_word(current_status_word), .mode(mode),
   .privileged(privileged), .irq_masked(irq_masked), .istate(istate));

// File: dv/brf_pipe_model.sv
// brf_pipe_model: stand-in for the execute pipeline feeding the register file
// assumes: bench sets fields after a falling edge; tick holds them over one rising edge
`timescale 1ns/1ps
module brf_pipe_model (
   input wire logic core_clk
);
   // ************************************************
   // request fields
   // ************************************************
   logic [3:0]  rd_a_spec, rd_b_spec, wr_spec, cond_flags_in, lane_compare_in;
   logic [31:0] wr_data, pc_target, status_wr_data, exc_return_addr;
   logic [2:0]  exc_kind;
   logic        wr_en, branch_with_link, pc_advance, pc_load, flags_we, sat_set, lane_we;
   logic        status_wr_cur, status_wr_saved, status_rd_saved, exc_req;
   // pulses drop at the next falling edge, so no rising edge sees one twice
   task automatic clear();
      {wr_en, branch_with_link, pc_advance, pc_load, flags_we, sat_set, lane_we} = '0;
      {status_wr_cur, status_wr_saved, exc_req} = '0;
   endtask : clear
   task automatic tick();
      @(negedge core_clk);
      clear();
   endtask : tick
   initial begin
      {rd_a_spec, rd_b_spec, wr_spec, cond_flags_in, lane_compare_in, exc_kind} = '0;
      {wr_data, pc_target, status_wr_data, exc_return_addr, status_rd_saved} = '0;
      clear();
   end
endmodule : brf_pipe_model

// File: dv/tb_top.sv
// tb_top: self-checking bench for the banked register file
// assumes: pipeline model drives every input except core_clk and rst, checker bound to brf_top
`timescale 1ns/1ps
module tb_top;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] rd_a_data, rd_b_data, status_rd_data, fetch_pc, current_status_word, v;
   logic [31:0] model [31];
   logic [4:0]  mode, m;
   logic [1:0]  istate;
   logic        privileged, big_endian, irq_masked, fast_irq_masked, abort_masked;
   logic [4:0]  modes [6] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
   logic [2:0]  kinds [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
   logic [4:0]  emode [6] = '{5'h1B, 5'h13, 5'h17, 5'h17, 5'h12, 5'h11};
   logic [31:0] evec [6] = '{32'h4, 32'h8, 32'hC, 32'h10, 32'h18, 32'h1C};
   int          fail_count = 0;
   int          comparisons = 0;
   brf_pipe_model p (.core_clk(core_clk));
   brf_top dut (.core_clk(core_clk), .rst(rst), .rd_a_spec(p.rd_a_spec), .rd_b_spec(p.rd_b_spec),
      .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .wr_en(p.wr_en), .wr_spec(p.wr_spec),
      .wr_data(p.wr_data), .branch_with_link(p.branch_with_link), .pc_advance(p.pc_advance),
      .pc_load(p.pc_load), .pc_target(p.pc_target), .flags_we(p.flags_we),
      .cond_flags_in(p.cond_flags_in), .sat_set(p.sat_set), .lane_we(p.lane_we),
      .lane_compare_in(p.lane_compare_in), .status_wr_cur(p.status_wr_cur),
      .status_wr_saved(p.status_wr_saved), .status_wr_data(p.status_wr_data),
      .status_rd_saved(p.status_rd_saved), .status_rd_data(status_rd_data), .exc_req(p.exc_req),
      .exc_kind(p.exc_kind), .exc_return_addr(p.exc_return_addr), .fetch_pc(fetch_pc),
      .current_status_word(current_status_word), .mode(mode), .privileged(privileged),
      .big_endian(big_endian), .irq_masked(irq_masked), .fast_irq_masked(fast_irq_masked),
      .abort_masked(abort_masked), .istate(istate));
   always #25 core_clk = ~core_clk;
   // ************************************************
   // expectations and drivers
   // ************************************************
   function automatic int phys(input logic [4:0] md, input logic [3:0] s);
      int base;
      case (md)
         5'h11: base = 20;
         5'h12: base = 22;
         5'h13: base = 24;
         5'h17: base = 26;
         5'h1B: base = 28;
         default: base = 0;
      endcase
      if (s > 4'hC && base != 0) return base + int'(s) - 13;
      if (s > 4'h7 && md == 5'h11) return int'(s) + 7;
      return int'(s);
   endfunction : phys
   // user writes keep the control half and state bit
   function automatic logic [31:0] stat_exp(input logic [31:0] old, input logic [31:0] d);
      if (old[4:0] == brf_pkg::MODE_USER) return {d[31:25], old[24], d[23:16], old[15:0]} & brf_pkg::STATUS_IMPL_MASK;
      return d & brf_pkg::STATUS_IMPL_MASK;
   endfunction : stat_exp
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   task automatic wreg(input logic [3:0] s, input logic [31:0] d);
      p.wr_en = 1'b1;
      p.wr_spec = s;
      p.wr_data = d;
      model[phys(mode, s)] = d;
      p.tick();
   endtask : wreg
   task automatic rreg(input logic [3:0] s);
      p.rd_a_spec = s;
      p.rd_b_spec = 4'hE - s;
      p.tick();
      chk(rd_a_data, model[phys(mode, s)]);
      chk(rd_b_data, model[phys(mode, 4'hE - s)]);
   endtask : rreg
   task automatic swr(input logic [31:0] d);
      v = stat_exp(current_status_word, d);
      p.status_wr_cur = 1'b1;
      p.status_wr_data = d;
      p.tick();
      chk(current_status_word, v);
   endtask : swr
   task automatic exc(input logic [2:0] k, input logic [31:0] r);
      p.exc_req = 1'b1;
      p.exc_kind = k;
      p.exc_return_addr = r;
      p.tick();
   endtask : exc
   task automatic pcload(input logic [31:0] t, input logic [31:0] e);
      p.pc_load = 1'b1;
      p.pc_target = t;
      p.tick();
      chk(fetch_pc, e);
   endtask : pcload
   initial begin
      void'($urandom(32'hFB3F1D90));
      for (int i = 0; i < 31; i++) model[i] = 32'h0;
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      chk(current_status_word, brf_pkg::STATUS_RESET);
      chk(fetch_pc, 32'h0);
      chk({29'h0, abort_masked, irq_masked, fast_irq_masked}, 32'h7);
      for (int i = 0; i < 200; i++) begin
         m = modes[$urandom_range(5)];
         swr({24'h0, 3'h6, m});
         wreg(4'($urandom_range(14)), $urandom());
         rreg(4'($urandom_range(14)));
      end
      foreach (kinds[j]) begin
         swr(32'hA000011F);
         exc(kinds[j], 32'h1000 + 32'(j));
         chk({27'h0, mode}, {27'h0, emode[j]});
         chk({29'h0, abort_masked, irq_masked, fast_irq_masked}, {29'h0, 2'h3, kinds[j] == 3'h7});
         chk(fetch_pc, evec[j]);
         model[phys(mode, 4'hE)] = 32'h1000 + 32'(j);
         rreg(4'h0);
         p.status_rd_saved = 1'b1;
         p.tick();
         chk(status_rd_data, 32'hA000011F);
         p.status_rd_saved = 1'b0;
      end
      exc(3'h0, 32'h0);
      chk({27'h0, mode}, 32'h13);
      pcload(32'h103, 32'h100);
      p.branch_with_link = 1'b1;
      p.tick();
      model[phys(mode, 4'hE)] = 32'h104;
      rreg(4'h0);
      p.rd_a_spec = 4'hF;
      p.pc_advance = 1'b1;
      p.tick();
      chk(rd_a_data, 32'h108);
      chk(fetch_pc, 32'h104);
      swr(32'h000000F3);
      chk({30'h0, istate}, 32'h1);
      pcload(32'h103, 32'h102);
      swr(32'h010000D3);
      pcload(32'h103, 32'h103);
      pcload(32'h200, 32'h200);
      swr(32'h000000D3);
      p.flags_we = 1'b1;
      p.cond_flags_in = 4'hA;
      p.sat_set = 1'b1;
      p.lane_we = 1'b1;
      p.lane_compare_in = 4'h5;
      p.tick();
      chk(current_status_word, 32'hA80500D3);
      p.flags_we = 1'b1;
      p.cond_flags_in = 4'h0;
      p.tick();
      chk(current_status_word, 32'h080500D3);
      swr(32'h06F0FC1F);
      swr(32'h000002DF);
      chk({31'h0, big_endian}, 32'h1);
      p.tick();
      chk(status_rd_data, 32'h000002DF);
      swr(32'h000000D0);
      chk({31'h0, privileged}, 32'h0);
      swr(32'hF00000DF);
      exc(3'h2, 32'h40);
      chk({27'h0, mode}, 32'h13);
      // saved word write in trap mode, read back through the saved select
      v = $urandom();
      p.status_wr_saved = 1'b1;
      p.status_wr_data = v;
      p.tick();
      p.status_rd_saved = 1'b1;
      p.tick();
      chk(status_rd_data, v & brf_pkg::STATUS_IMPL_MASK);
      p.status_rd_saved = 1'b0;
      conclude();
   end
   initial begin
      #1000000;
      fail_count++;
      conclude();
   end
endmodule : tb_top
